//--- core/wgas_pkg.sv
/*
  Shared constants for the waveform generator auto-shutdown block:
  register offsets, field positions, reset values and encodings.
  Assumes an 8-bit register port with plain strobes.
*/
package wgas_pkg;

  // Register offsets on the 12-bit register port
  localparam logic [11:0] CLOCK_SOURCE_SELECT_OFS     = 12'hF3B;
  localparam logic [11:0] INPUT_SOURCE_SELECT_OFS     = 12'hF3C;
  localparam logic [11:0] RISE_DEADBAND_COUNT_OFS     = 12'hF3D;
  localparam logic [11:0] FALL_DEADBAND_COUNT_OFS     = 12'hF3E;
  localparam logic [11:0] MODE_ENABLE_CONTROL_OFS     = 12'hF3F;
  localparam logic [11:0] OUTPUT_POLARITY_CONTROL_OFS = 12'hF40;
  localparam logic [11:0] SHUTDOWN_CONTROL_OFS        = 12'hF41;
  localparam logic [11:0] SHUTDOWN_SOURCE_ENABLE_OFS  = 12'hF42;
  localparam logic [11:0] OUTPUT_STEERING_CONTROL_OFS = 12'hF43;

  // Field positions
  localparam int ENABLE_BIT      = 7;
  localparam int LOAD_BIT        = 6;
  localparam int SHUTDOWN_BIT    = 7;
  localparam int RESTART_BIT     = 6;
  localparam int BD_LEVEL_LSB    = 4;
  localparam int AC_LEVEL_LSB    = 2;
  localparam int INPUT_VALUE_BIT = 5;
  localparam int DEADBAND_W      = 6;

  // Reset values
  localparam logic [7:0] SHUTDOWN_CONTROL_RST = 8'h94;
  localparam logic [7:0] ZERO_RST             = 8'h00;

  // Fault sources that shut down on a high level; the rest on low
  localparam logic [7:0] FAULT_ACTIVE_HIGH = 8'h0E;

  // Override level encodings
  typedef enum logic [1:0] {
    WGAS_OVR_INACTIVE = 2'h0,
    WGAS_OVR_TRISTATE = 2'h1,
    WGAS_OVR_LOW      = 2'h2,
    WGAS_OVR_HIGH     = 2'h3
  } wgas_ovr_e;

  // Run state of the generator, Gray coded
  typedef enum logic [1:0] {
    WGAS_ST_SHUT = 2'h0,
    WGAS_ST_WAIT = 2'h1,
    WGAS_ST_RUN  = 2'h3
  } wgas_state_e;

endpackage

//--- core/wgas_outcell.sv
/*
  One output cell: picks the running waveform or the override level,
  and forms the pin output and active-low output enable.
  Assumes the fault term is already combined; path is combinational.
*/
`timescale 1ns/100ps
`default_nettype none
module wgas_outcell
  import wgas_pkg::*;
(
  // Waveform side
  input  wire logic       run_level_i,
  input  wire logic       polarity_i,
  // Override side
  input  wire logic       force_i,
  input  wire logic [1:0] level_sel_i,
  // Pin side
  output logic            pin_o,
  output logic            pin_oe_n_o
);

  // Override decode, not polarity adjusted except for inactive level
  always_comb begin
    pin_o      = run_level_i;
    pin_oe_n_o = 1'b0;
    if (force_i) begin
      unique case (level_sel_i)
        WGAS_OVR_HIGH:     pin_o = 1'b1;
        WGAS_OVR_LOW:      pin_o = 1'b0;
        WGAS_OVR_TRISTATE: begin
          pin_o      = 1'b0;
          pin_oe_n_o = 1'b1;
        end
        WGAS_OVR_INACTIVE: pin_o = polarity_i;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- core/wgas_top.sv
/*
  Auto-shutdown, restart and register bank of a four-output
  complementary waveform generator.
  Assumes fault and data inputs synchronous to clk_sys_i; a simple
  register port with read data one cycle after the read strobe.
*/
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module wgas_top
  import wgas_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // Register port
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [7:0]  reg_rdata_o,
  // Data inputs, indexed by input_select_field
  input  wire logic [15:0] data_sources_i,
  // Fault sources: 7 logic_cell_six_output, 6 logic_cell_two_output,
  // 5 comparator_two_output, 4 comparator_one_output,
  // 3..1 timer six/four/two postscaler out, 0 fault_pin_select
  input  wire logic [7:0]  fault_sources_i,
  // Sleep status
  input  wire logic        sleep_i,
  // Outputs A..D with active-low output enables
  output logic      [3:0]  wave_o,
  output logic      [3:0]  wave_oe_n_o,
  // Status
  output logic             waveform_irq_flag_o,
  output logic             internal_fast_oscillator_keep_o
);

  // Registers
  logic [7:0] clock_source_select;
  logic [3:0] input_select_field;
  logic [DEADBAND_W-1:0] rise_deadband_field;
  logic [DEADBAND_W-1:0] fall_deadband_field;
  logic       module_enable;
  logic       deadband_load_bit;
  logic [2:0] mode_field;
  logic [3:0] output_polarity_bit;
  logic       shutdown_flag;
  logic       restart_enable;
  logic [1:0] bd_override_level;
  logic [1:0] ac_override_level;
  logic [7:0] fault_source_enable;
  logic [3:0] steer_enable_bit;
  logic [3:0] steer_level_bit;
  wgas_state_e state;
  logic       data_prev;
  logic       data_in;
  logic       fault_now;
  logic [7:0] fault_active;
  logic       wr_shut;
  logic       next_shutdown;
  logic       rising_data;
  logic       force_ovr;
  logic [3:0] run_level;
  logic [3:0] cell_pin;
  logic [3:0] cell_oe_n;

  // Selected data input
  assign data_in     = data_sources_i[input_select_field];
  assign rising_data = data_in & ~data_prev;

  // Level-sensitive fault qualification, mixed active levels
  assign fault_active = (fault_sources_i ~^ FAULT_ACTIVE_HIGH)
                      & fault_source_enable;
  assign fault_now    = |fault_active;

  assign wr_shut = reg_write_i && (reg_addr_i == SHUTDOWN_CONTROL_OFS);

  // Shutdown flag next value: any set beats any clear
  // A software set under auto-restart stands one cycle, then clears;
  // letting the clear win would swallow the shutdown request entirely
  always_comb begin
    next_shutdown = shutdown_flag;
    if (restart_enable && !fault_now) begin
      next_shutdown = 1'b0;
    end
    if (wr_shut) begin
      if (reg_wdata_i[SHUTDOWN_BIT]) begin
        next_shutdown = 1'b1;
      end else if (!fault_now) begin
        next_shutdown = 1'b0;
      end
    end
    if (fault_now) begin
      next_shutdown = 1'b1;
    end
  end

  // Shutdown flag, set at reset so start-up is shut down
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shutdown_flag <= SHUTDOWN_CONTROL_RST[SHUTDOWN_BIT];
    end else begin
      shutdown_flag <= next_shutdown;
    end
  end

  // Interrupt flag pulses on each flag set, hardware or software
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      waveform_irq_flag_o <= 1'b0;
    end else begin
      waveform_irq_flag_o <= next_shutdown & ~shutdown_flag;
    end
  end

  // Run state: leaving shutdown waits for a rising data edge
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= WGAS_ST_SHUT;
    end else begin
      unique case (state)
        WGAS_ST_SHUT: if (!shutdown_flag) state <= WGAS_ST_WAIT;
        WGAS_ST_WAIT: begin
          if (shutdown_flag) begin
            state <= WGAS_ST_SHUT;
          end else if (rising_data) begin
            state <= WGAS_ST_RUN;
          end
        end
        WGAS_ST_RUN:  if (shutdown_flag) state <= WGAS_ST_SHUT;
        default:      state <= WGAS_ST_SHUT;
      endcase
    end
  end

  // Data edge history
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      data_prev <= 1'b0;
    end else begin
      data_prev <= data_in;
    end
  end

  // Override is forced combinationally by faults, without waiting for the flag
  assign force_ovr = fault_now || (state != WGAS_ST_RUN);

  // Running level: simple steering waveform with polarity
  assign run_level = module_enable ?
    ((steer_enable_bit & {4{data_in ^ 1'b0}} ^ output_polarity_bit)
      & steer_enable_bit) | (steer_level_bit & ~steer_enable_bit)
    : output_polarity_bit;

  // One output cell per output; A and C share one field, B and D other
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cell
      wgas_outcell u_cell (
        .run_level_i (run_level[gi]),
        .polarity_i  (output_polarity_bit[gi]),
        .force_i     (force_ovr),
        .level_sel_i ((gi % 2 == 0) ? ac_override_level
                                    : bd_override_level),
        .pin_o       (cell_pin[gi]),
        .pin_oe_n_o  (cell_oe_n[gi])
      );
    end
  endgenerate

  // Registered pin outputs; adds one cycle after the fault decode
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wave_o      <= 4'h0;
      wave_oe_n_o <= 4'hF;
    end else begin
      wave_o      <= cell_pin;
      wave_oe_n_o <= cell_oe_n;
    end
  end

  // Keep internal oscillator alive in sleep when it clocks us, while enabled and the data input is high
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      internal_fast_oscillator_keep_o <= 1'b0;
    end else begin
      internal_fast_oscillator_keep_o <= sleep_i && module_enable
        && clock_source_select[0] && data_in;
    end
  end

  // Configuration register writes
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      clock_source_select <= ZERO_RST;
      input_select_field  <= 4'h0;
      rise_deadband_field <= 6'h00;
      fall_deadband_field <= 6'h00;
      module_enable       <= 1'b0;
      mode_field          <= 3'h0;
      output_polarity_bit <= 4'h0;
      restart_enable      <= SHUTDOWN_CONTROL_RST[RESTART_BIT];
      bd_override_level   <= SHUTDOWN_CONTROL_RST[BD_LEVEL_LSB +: 2];
      ac_override_level   <= SHUTDOWN_CONTROL_RST[AC_LEVEL_LSB +: 2];
      fault_source_enable <= ZERO_RST;
      steer_enable_bit    <= 4'h0;
      steer_level_bit     <= 4'h0;
    end else if (reg_write_i) begin
      unique case (reg_addr_i)
        CLOCK_SOURCE_SELECT_OFS: clock_source_select <=
                                   {7'h00, reg_wdata_i[0]};
        INPUT_SOURCE_SELECT_OFS: input_select_field <= reg_wdata_i[3:0];
        RISE_DEADBAND_COUNT_OFS:
          rise_deadband_field <= reg_wdata_i[DEADBAND_W-1:0];
        FALL_DEADBAND_COUNT_OFS:
          fall_deadband_field <= reg_wdata_i[DEADBAND_W-1:0];
        MODE_ENABLE_CONTROL_OFS: begin
          module_enable <= reg_wdata_i[ENABLE_BIT];
          mode_field    <= reg_wdata_i[2:0];
        end
        OUTPUT_POLARITY_CONTROL_OFS:
          output_polarity_bit <= reg_wdata_i[3:0];
        SHUTDOWN_CONTROL_OFS: begin
          restart_enable    <= reg_wdata_i[RESTART_BIT];
          bd_override_level <= reg_wdata_i[BD_LEVEL_LSB +: 2];
          ac_override_level <= reg_wdata_i[AC_LEVEL_LSB +: 2];
        end
        SHUTDOWN_SOURCE_ENABLE_OFS: fault_source_enable <= reg_wdata_i;
        OUTPUT_STEERING_CONTROL_OFS: begin
          steer_level_bit  <= reg_wdata_i[7:4];
          steer_enable_bit <= reg_wdata_i[3:0];
        end
        default: ;
      endcase
    end
  end

  // Load bit: set only when already enabled, cleared by a data rise
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      deadband_load_bit <= 1'b0;
    end else if (reg_write_i && reg_addr_i == MODE_ENABLE_CONTROL_OFS
                 && module_enable && reg_wdata_i[LOAD_BIT]) begin
      deadband_load_bit <= 1'b1;
    end else if (deadband_load_bit && (rising_data || !module_enable)) begin
      deadband_load_bit <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= ZERO_RST;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        CLOCK_SOURCE_SELECT_OFS: reg_rdata_o <= clock_source_select;
        INPUT_SOURCE_SELECT_OFS: reg_rdata_o <= {4'h0, input_select_field};
        RISE_DEADBAND_COUNT_OFS: reg_rdata_o <= {2'h0, rise_deadband_field};
        FALL_DEADBAND_COUNT_OFS: reg_rdata_o <= {2'h0, fall_deadband_field};
        MODE_ENABLE_CONTROL_OFS:
          reg_rdata_o <= {module_enable, deadband_load_bit, 3'h0, mode_field};
        OUTPUT_POLARITY_CONTROL_OFS:
          reg_rdata_o <= {2'h0, data_in, 1'b0, output_polarity_bit};
        SHUTDOWN_CONTROL_OFS:
          reg_rdata_o <= {shutdown_flag, restart_enable, bd_override_level,
                          ac_override_level, 2'h0};
        SHUTDOWN_SOURCE_ENABLE_OFS: reg_rdata_o <= fault_source_enable;
        OUTPUT_STEERING_CONTROL_OFS:
          reg_rdata_o <= {steer_level_bit, steer_enable_bit};
        default: reg_rdata_o <= ZERO_RST;
      endcase
    end else begin
      reg_rdata_o <= ZERO_RST;
    end
  end

  // Checks
  a_fault_sets_flag: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) fault_now |=> shutdown_flag)
    else $error("fault did not hold shutdown flag");
  a_fault_forces_out: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) fault_now && bd_override_level == WGAS_OVR_LOW
    |=> !wave_o[1] && !wave_o[3] && !wave_oe_n_o[1])
    else $error("fault did not force override");
  a_fault_blocks_run: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) fault_now |-> ##2 state == WGAS_ST_SHUT)
    else $error("run state kept during fault");
  a_load_needs_en: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) $rose(deadband_load_bit) |-> $past(module_enable))
    else $error("load bit set while disabled");
  a_irq_on_set: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) $rose(shutdown_flag) |-> waveform_irq_flag_o)
    else $error("interrupt flag missing on shutdown");
  a_sw_set_shut: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) wr_shut && reg_wdata_i[SHUTDOWN_BIT]
    |=> shutdown_flag ##1 state == WGAS_ST_SHUT)
    else $error("software shutdown not taken");
  a_hold_no_restart: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) shutdown_flag && !restart_enable && !wr_shut
    |=> shutdown_flag)
    else $error("flag cleared without software");
  a_clear_ignored: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) wr_shut && fault_now |=> shutdown_flag)
    else $error("clear accepted during fault");
  a_auto_clear: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) restart_enable && !fault_now && !wr_shut
    |=> !shutdown_flag)
    else $error("auto restart did not clear flag");
  a_resume_on_edge: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) $rose(state == WGAS_ST_RUN)
    |-> $past(rising_data) && !$past(shutdown_flag))
    else $error("resumed without rising data edge");
  a_out_registered: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) force_ovr && ac_override_level == WGAS_OVR_HIGH
    |=> wave_o[0] && wave_o[2])
    else $error("A/C override level not driven");
  c_fault_shutdown: cover property (@(posedge clk_sys_i)
    disable iff (reset_i) $rose(fault_now));
  c_auto_restart: cover property (@(posedge clk_sys_i)
    disable iff (reset_i) restart_enable && $fell(shutdown_flag));
  c_sw_restart: cover property (@(posedge clk_sys_i)
    disable iff (reset_i) !restart_enable && $fell(shutdown_flag));
  c_running: cover property (@(posedge clk_sys_i)
    disable iff (reset_i) $rose(state == WGAS_ST_RUN));
  c_sw_shut_auto: cover property (@(posedge clk_sys_i)
    disable iff (reset_i) restart_enable && wr_shut
    && reg_wdata_i[SHUTDOWN_BIT]);

endmodule
`default_nettype wire

//--- tb/wgas_pad_model.sv
/*
  Pad model for the four generator outputs as the switch drivers
  see them: a released pin is pulled low by the board.
  Assumes active-low output enables from the design.
*/
`timescale 1ns/100ps
`default_nettype none
module wgas_pad_model (
  // From the design
  input  wire logic [3:0] drive_i,
  input  wire logic [3:0] oe_n_i,
  // Pin levels
  output logic      [3:0] pin_o
);
  // Released pins fall to the pull-down, never keep the last level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_o[i] = oe_n_i[i] ? 1'b0 : drive_i[i];
    end
  end
endmodule
`default_nettype wire

//--- tb/wgas_top_tb.sv
/*
  Self-checking bench for the auto-shutdown block: register tasks,
  fault and data stimulus, pin and flag checks.
  Assumes one 100 MHz clock and the pad model on the outputs.
*/
`timescale 1ns/100ps
`default_nettype none
module wgas_top_tb
  import wgas_pkg::*;
;
  localparam logic [7:0] IDLE = 8'hF1; // Inactive fault levels
  localparam logic [7:0] LV   = 8'h2C; // B/D low, A/C high
  localparam logic [3:0] POL  = 4'h3;
  logic        clk_sys_i;
  logic        reset_i;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  flt;
  logic        wr;
  logic        rd;
  logic        slp;
  logic        keep;
  logic        irq;
  logic [15:0] src;
  logic [3:0]  wave;
  logic [3:0]  oe_n;
  logic [3:0]  pin;
  int          n_fail = 0;
  int          compares = 0;
  int          n_irq = 0;
  int          base;

  // Free-running system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  wgas_top dut (
    .clk_sys_i                      (clk_sys_i),
    .reset_i                        (reset_i),
    .reg_addr_i                     (addr),
    .reg_wdata_i                    (wdata),
    .reg_write_i                    (wr),
    .reg_read_i                     (rd),
    .reg_rdata_o                    (rdata),
    .data_sources_i                 (src),
    .fault_sources_i                (flt),
    .sleep_i                        (slp),
    .wave_o                         (wave),
    .wave_oe_n_o                    (oe_n),
    .waveform_irq_flag_o            (irq),
    .internal_fast_oscillator_keep_o(keep)
  );

  wgas_pad_model pads (
    .drive_i(wave),
    .oe_n_i (oe_n),
    .pin_o  (pin)
  );

  // Counts interrupt pulses; one per flag set event
  always @(posedge clk_sys_i) begin
    if (irq === 1'b1) begin
      n_irq <= n_irq + 1;
    end
  end

  task automatic wrap_up;
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register port cycles, one strobe cycle each
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic data(input logic v);
    @(posedge clk_sys_i);
    src[0] <= v;
  endtask

  task automatic fault(input logic [7:0] v);
    @(posedge clk_sys_i);
    flt <= v;
  endtask

  // Lets the output flops and the run state settle before a look
  task automatic settle;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic pins(input logic [7:0] e);
    settle();
    chk({oe_n, pin}, e);
  endtask

  // Software restart; data must fall first so a rise is seen
  task automatic restart;
    wr_reg(SHUTDOWN_CONTROL_OFS, LV);
    data(1'b0);
    data(1'b1);
  endtask

  // Expected {oe_n, pin} for override codes; tristate reads pulled low
  function automatic logic [7:0] ovr_exp(input int ac, input int bd);
    logic [3:0] w;
    logic [3:0] o;
    int         c;
    for (int i = 0; i < 4; i++) begin
      c    = (i % 2) ? bd : ac;
      o[i] = (c == 1);
      w[i] = (c == 3) || (c == 0 && POL[i]);
    end
    return {o, w};
  endfunction

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    wrap_up();
  end

  // Main sequence
  initial begin
    reset_i = 1'b1;
    addr    = 12'h000;
    wdata   = 8'h00;
    wr      = 1'b0;
    rd      = 1'b0;
    src     = 16'h0000;
    flt     = IDLE;
    slp     = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd_chk(SHUTDOWN_CONTROL_OFS, SHUTDOWN_CONTROL_RST);
    rd_chk(MODE_ENABLE_CONTROL_OFS, ZERO_RST);
    pins(8'hF0);
    rd_chk(12'hF44, 8'h00);
    wr_reg(RISE_DEADBAND_COUNT_OFS, 8'hFF);
    rd_chk(RISE_DEADBAND_COUNT_OFS, 8'h3F);
    wr_reg(FALL_DEADBAND_COUNT_OFS, 8'hFF);
    rd_chk(FALL_DEADBAND_COUNT_OFS, 8'h3F);
    // Configure while disabled, enable last
    wr_reg(INPUT_SOURCE_SELECT_OFS, 8'h00);
    wr_reg(OUTPUT_POLARITY_CONTROL_OFS, {4'h0, POL});
    wr_reg(OUTPUT_STEERING_CONTROL_OFS, 8'h0F);
    wr_reg(MODE_ENABLE_CONTROL_OFS, 8'h80);
    pins(8'hF0);
    // Every override code, pairs set apart
    for (int c = 0; c < 4; c++) begin
      wr_reg(SHUTDOWN_CONTROL_OFS, 8'(128 + 16 * (3 - c) + 4 * c));
      pins(ovr_exp(c, 3 - c));
    end
    wr_reg(SHUTDOWN_CONTROL_OFS, LV);
    rd_chk(SHUTDOWN_CONTROL_OFS, LV);
    pins(8'h05);
    data(1'b1);
    pins(8'h0C);
    wr_reg(MODE_ENABLE_CONTROL_OFS, 8'hC0);
    rd_chk(MODE_ENABLE_CONTROL_OFS, 8'hC0);
    data(1'b0);
    data(1'b1);
    rd_chk(MODE_ENABLE_CONTROL_OFS, 8'h80);
    // Software shutdown holds without auto-restart
    base = n_irq;
    wr_reg(SHUTDOWN_CONTROL_OFS, 8'h80 | LV);
    pins(8'h05);
    chk(8'(n_irq - base), 8'h01);
    rd_chk(SHUTDOWN_CONTROL_OFS, 8'h80 | LV);
    restart();
    pins(8'h0C);
    // A disabled source must not shut down
    wr_reg(SHUTDOWN_SOURCE_ENABLE_OFS, 8'h01);
    fault(IDLE ^ 8'hFE);
    pins(8'h0C);
    fault(IDLE);
    // Each source alone, at its own active level
    for (int i = 0; i < 8; i++) begin
      base = n_irq;
      wr_reg(SHUTDOWN_SOURCE_ENABLE_OFS, 8'(1 << i));
      fault(IDLE ^ 8'(1 << i));
      pins(8'h05);
      chk(8'(n_irq - base), 8'h01);
      wr_reg(SHUTDOWN_CONTROL_OFS, LV);
      rd_chk(SHUTDOWN_CONTROL_OFS, 8'h80 | LV);
      fault(IDLE);
      rd_chk(SHUTDOWN_CONTROL_OFS, 8'h80 | LV);
      restart();
      pins(8'h0C);
    end
    // Auto-restart: two faults, one removed, the other disabled
    wr_reg(SHUTDOWN_CONTROL_OFS, 8'h40 | LV);
    wr_reg(SHUTDOWN_SOURCE_ENABLE_OFS, 8'h03);
    fault(IDLE ^ 8'h03);
    pins(8'h05);
    fault(IDLE ^ 8'h02);
    settle();
    rd_chk(SHUTDOWN_CONTROL_OFS, 8'hC0 | LV);
    wr_reg(SHUTDOWN_SOURCE_ENABLE_OFS, 8'h01);
    settle();
    rd_chk(SHUTDOWN_CONTROL_OFS, 8'h40 | LV);
    data(1'b0);
    pins(8'h05);
    data(1'b1);
    pins(8'h0C);
    fault(IDLE);
    // Software shutdown under auto-restart: brief, then waits for a rise
    base = n_irq;
    wr_reg(SHUTDOWN_CONTROL_OFS, 8'hC0 | LV);
    pins(8'h05);
    chk(8'(n_irq - base), 8'h01);
    rd_chk(SHUTDOWN_CONTROL_OFS, 8'h40 | LV);
    data(1'b0);
    data(1'b1);
    pins(8'h0C);
    // Oscillator hold in sleep follows data input
    wr_reg(CLOCK_SOURCE_SELECT_OFS, 8'h01);
    @(posedge clk_sys_i);
    slp <= 1'b1;
    settle();
    chk({7'h00, keep}, 8'h01);
    data(1'b0);
    settle();
    chk({7'h00, keep}, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
